//--- hdl/dcc_checker.sv
// dual channel discrepancy checker with ahb-lite register slave
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dcc_checker #(
  parameter int STEP_CYC = dcc_pkg::STEP_CYC,
  parameter int CONV_CYC = dcc_pkg::CONV_CYC
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // channel pins
  input wire logic [15:0] ch_a_in,
  input wire logic [15:0] ch_b_in,
  input wire logic ch_a_fault,
  input wire logic ch_b_fault,
  // process side
  output logic [15:0] process_value,
  output logic disc_active,
  output logic disc_error,
  output logic ack_required,
  output logic diag_irq
);
  // ==========================================================
  // functions
  function automatic logic [15:0] deviation(input logic [7:0] tenths, input logic [15:0] span);
    logic [31:0] prod;
    prod = {24'h000000, tenths} * {16'h0000, span};
    deviation = 16'(prod / dcc_pkg::TOL_DIV);
  endfunction : deviation

  function automatic logic [15:0] round_ms(input logic [15:0] ms);
    logic [15:0] units;
    units = 16'(({16'h0000, ms} + 32'h5) / {16'h0000, dcc_pkg::DISC_STEP_MS});
    if (ms != 16'h0000 && units < dcc_pkg::DISC_MIN_UNITS) begin
      units = dcc_pkg::DISC_MIN_UNITS;
    end
    round_ms = units;
  endfunction : round_ms

  function automatic logic tol_ok(input logic [7:0] t);
    tol_ok = (t >= dcc_pkg::TOL_MIN) && (t <= dcc_pkg::TOL_MAX);
  endfunction : tol_ok

  // ==========================================================
  // pin synchronisers
  logic [15:0] a_meta_ff, a_sync_ff, b_meta_ff, b_sync_ff;
  logic [1:0] f_meta_ff, f_sync_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_meta_ff <= 16'h0000;
      a_sync_ff <= 16'h0000;
      b_meta_ff <= 16'h0000;
      b_sync_ff <= 16'h0000;
      f_meta_ff <= 2'h0;
      f_sync_ff <= 2'h0;
    end else if (ce) begin
      a_meta_ff <= ch_a_in;
      a_sync_ff <= a_meta_ff;
      b_meta_ff <= ch_b_in;
      b_sync_ff <= b_meta_ff;
      f_meta_ff <= {ch_b_fault, ch_a_fault};
      f_sync_ff <= f_meta_ff;
    end
  end

  // ==========================================================
  // timebase: conversion cycle and 10 ms step
  logic [31:0] conv_cnt_ff, step_cnt_ff;
  logic conv_tick_ff, step_tick_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_cnt_ff <= 32'h0;
      step_cnt_ff <= 32'h0;
      conv_tick_ff <= 1'b0;
      step_tick_ff <= 1'b0;
    end else if (ce) begin
      conv_tick_ff <= (conv_cnt_ff == 32'(CONV_CYC - 1));
      conv_cnt_ff <= (conv_cnt_ff == 32'(CONV_CYC - 1)) ? 32'h0 : conv_cnt_ff + 32'h1;
      step_tick_ff <= (step_cnt_ff == 32'(STEP_CYC - 1));
      step_cnt_ff <= (step_cnt_ff == 32'(STEP_CYC - 1)) ? 32'h0 : step_cnt_ff + 32'h1;
    end
  end

  // ==========================================================
  // registers and ahb-lite slave, zero wait states
  logic [dcc_pkg::CTRL_W-1:0] ctrl_ff;
  logic [15:0] disc_units_ff;
  logic [7:0] tol_abs_ff, tol_rel_ff;
  logic [7:0] wr_addr_ff;
  logic wr_pend_ff;
  logic [31:0] rdata_ff;
  logic [31:0] status_word;
  logic addr_phase, ack_wr;
  logic disc_ff, err_ff, ack_req_ff, fresh_ff;
  logic [15:0] pv_ff;

  assign addr_phase = hsel && hready && htrans[1];
  assign ack_wr = wr_pend_ff && (wr_addr_ff == dcc_pkg::ADDR_ACK) && hwdata[0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign status_word = {pv_ff, 12'h000, fresh_ff, ack_req_ff, err_ff, disc_ff};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0;
    end else if (ce) begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_addr_ff <= haddr;
      if (addr_phase && !hwrite) begin
        case (haddr)
          dcc_pkg::ADDR_CTRL: rdata_ff <= {23'h0, ctrl_ff};
          dcc_pkg::ADDR_DISC_TIME: rdata_ff <= {16'h0, disc_units_ff};
          dcc_pkg::ADDR_TOL: rdata_ff <= {16'h0, tol_rel_ff, tol_abs_ff};
          dcc_pkg::ADDR_STATUS: rdata_ff <= status_word;
          default: rdata_ff <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= dcc_pkg::CTRL_RESET;
      disc_units_ff <= dcc_pkg::DISC_RESET_UNITS;
      tol_abs_ff <= dcc_pkg::TOL_RESET;
      tol_rel_ff <= dcc_pkg::TOL_RESET;
    end else if (ce && wr_pend_ff) begin
      case (wr_addr_ff)
        dcc_pkg::ADDR_CTRL: ctrl_ff <= hwdata[dcc_pkg::CTRL_W-1:0];
        dcc_pkg::ADDR_DISC_TIME: begin
          // out-of-range times saturate at the longest time allowed
          if (hwdata[15:0] > dcc_pkg::DISC_MAX_MS) begin
            disc_units_ff <= round_ms(dcc_pkg::DISC_MAX_MS);
          end else begin
            disc_units_ff <= round_ms(hwdata[15:0]);
          end
        end
        dcc_pkg::ADDR_TOL: begin
          if (tol_ok(hwdata[dcc_pkg::TOL_ABS_LO +: 8])) begin
            tol_abs_ff <= hwdata[dcc_pkg::TOL_ABS_LO +: 8];
          end
          if (tol_ok(hwdata[dcc_pkg::TOL_REL_LO +: 8])) begin
            tol_rel_ff <= hwdata[dcc_pkg::TOL_REL_LO +: 8];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // smoothing, restarted by channel faults only
  logic restart;
  logic [15:0] avg_a, avg_b;
  logic valid_a, valid_b;
  assign restart = |f_sync_ff;

  dcc_smoother u_smooth_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .sample_en(conv_tick_ff),
    .restart(restart),
    .depth_code(ctrl_ff[dcc_pkg::CTRL_SMOOTH_LO +: 2]),
    .sample(a_sync_ff),
    .avg_ff(avg_a),
    .valid_ff(valid_a)
  );

  dcc_smoother u_smooth_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .sample_en(conv_tick_ff),
    .restart(restart),
    .depth_code(ctrl_ff[dcc_pkg::CTRL_SMOOTH_LO +: 2]),
    .sample(b_sync_ff),
    .avg_ff(avg_b),
    .valid_ff(valid_b)
  );

  // ==========================================================
  // window and comparison
  logic dual, eval, disc_now, expire, set_err, set_ack_req;
  logic [15:0] rep, other, diff, start, rep_off, dev_abs, dev_rel, tol;
  logic [15:0] timer_ff, held_ff;

  assign dual = ctrl_ff[dcc_pkg::CTRL_DUAL];
  assign start = ctrl_ff[dcc_pkg::CTRL_RANGE_4MA] ? dcc_pkg::START_4MA : dcc_pkg::START_0MA;
  assign rep = (ctrl_ff[dcc_pkg::CTRL_SEL_MAX] == (avg_a > avg_b)) ? avg_a : avg_b;
  assign other = (rep == avg_a) ? avg_b : avg_a;
  assign diff = (rep > other) ? 16'(rep - other) : 16'(other - rep);
  assign rep_off = (rep > start) ? 16'(rep - start) : 16'(start - rep);
  assign dev_abs = deviation(tol_abs_ff, 16'(dcc_pkg::RANGE_END - start));
  assign dev_rel = deviation(tol_rel_ff, rep_off);

  always_comb begin
    tol = 16'h0000;
    if (ctrl_ff[dcc_pkg::CTRL_ABS_EN]) begin
      tol = dev_abs;
    end
    if (ctrl_ff[dcc_pkg::CTRL_REL_EN] && dev_rel > tol) begin
      tol = dev_rel;
    end
  end

  assign eval = ce && conv_tick_ff && dual && valid_a && valid_b && !restart;
  assign disc_now = diff > tol;
  // expiry seen at a conversion boundary keeps error within the bound
  assign expire = timer_ff >= disc_units_ff;
  assign set_err = eval && disc_ff && expire && disc_now;
  assign set_ack_req = eval && disc_ff && expire && !disc_now;

  // ==========================================================
  // discrepancy state and timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disc_ff <= 1'b0;
      timer_ff <= 16'h0000;
    end else if (ce) begin
      if (restart || !dual) begin
        disc_ff <= 1'b0;
        timer_ff <= 16'h0000;
      end else if (eval) begin
        if (!disc_ff) begin
          if (disc_now) begin
            disc_ff <= 1'b1;
            timer_ff <= 16'h0000;
          end
        end else if (expire || !disc_now) begin
          disc_ff <= 1'b0;
          timer_ff <= 16'h0000;
        end
      end else if (disc_ff && step_tick_ff && timer_ff != 16'hffff) begin
        timer_ff <= timer_ff + 16'h0001;
      end
    end
  end

  // ==========================================================
  // error, acknowledge and startup flags; a set beats an acknowledge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_ff <= 1'b0;
      ack_req_ff <= 1'b0;
      fresh_ff <= 1'b1;
      diag_irq <= 1'b0;
    end else if (ce) begin
      err_ff <= set_err || (err_ff && !ack_wr);
      ack_req_ff <= set_ack_req || (ack_req_ff && !ack_wr);
      diag_irq <= set_err && ctrl_ff[dcc_pkg::CTRL_IRQ_EN];
      if (restart) begin
        fresh_ff <= 1'b1;
      end else if (eval && !disc_ff && !disc_now) begin
        fresh_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // reported process value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pv_ff <= dcc_pkg::ERR_CODE;
      held_ff <= 16'h0000;
    end else if (ce) begin
      if (set_err || (err_ff && !ack_wr)) begin
        pv_ff <= dcc_pkg::ERR_CODE;
      end else if (!dual) begin
        if (conv_tick_ff && valid_a && !restart) begin
          pv_ff <= avg_a;
        end
      end else if (eval) begin
        if (!disc_ff && disc_now) begin
          pv_ff <= fresh_ff ? dcc_pkg::ERR_CODE : held_ff;
        end else if (!disc_now) begin
          pv_ff <= rep;
          held_ff <= rep;
        end
      end
    end
  end

  assign process_value = pv_ff;
  assign disc_active = disc_ff;
  assign disc_error = err_ff;
  assign ack_required = ack_req_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_disc_expiring;
    eval && disc_ff && expire;
  endsequence
  sequence s_err_shown;
    err_ff && process_value == dcc_pkg::ERR_CODE;
  endsequence

  property p_single_quiet;
    ce && !dual |=> !disc_ff;
  endproperty
  a_single_quiet: assert property (p_single_quiet) else $error("discrepancy in single mode");
  property p_disc_start;
    eval && !disc_ff && disc_now |=> disc_ff && timer_ff == 16'h0000;
  endproperty
  a_disc_start: assert property (p_disc_start) else $error("discrepancy not started");
  property p_hold;
    eval && !disc_ff && disc_now && !fresh_ff && !err_ff |=> process_value == $past(held_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("held value not reported");
  property p_clear;
    eval && disc_ff && !expire && !disc_now && !restart |=> !disc_ff && timer_ff == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("timer not cleared");
  property p_fresh;
    eval && !disc_ff && disc_now && fresh_ff |=> process_value == dcc_pkg::ERR_CODE ##0 disc_ff;
  endproperty
  a_fresh: assert property (p_fresh) else $error("startup discrepancy not flagged");
  property p_healed;
    s_disc_expiring ##0 !disc_now && !err_ff |=> ack_required && process_value == $past(rep);
  endproperty
  a_healed: assert property (p_healed) else $error("healed expiry wrong");
  property p_expire_err;
    s_disc_expiring ##0 disc_now |=> s_err_shown ##0 (diag_irq == ctrl_ff[dcc_pkg::CTRL_IRQ_EN]);
  endproperty
  a_expire_err: assert property (p_expire_err) else $error("expiry error missing");
  property p_sticky;
    ce && err_ff && !ack_wr |=> s_err_shown;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");
  property p_tol_range;
    ce |-> tol_abs_ff >= dcc_pkg::TOL_MIN && tol_abs_ff <= dcc_pkg::TOL_MAX
      && tol_rel_ff >= dcc_pkg::TOL_MIN && tol_rel_ff <= dcc_pkg::TOL_MAX;
  endproperty
  a_tol_range: assert property (p_tol_range) else $error("tolerance out of range");
endmodule : dcc_checker
`default_nettype wire

//--- hdl/dcc_pkg.sv
// constants and register map of the dual channel discrepancy checker
package dcc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DISC_TIME = 8'h04;
  localparam logic [7:0] ADDR_TOL = 8'h08;
  localparam logic [7:0] ADDR_ACK = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // control fields
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_SEL_MAX = 1;
  localparam int CTRL_RANGE_4MA = 2;
  localparam int CTRL_SMOOTH_LO = 4;
  localparam int CTRL_ABS_EN = 6;
  localparam int CTRL_REL_EN = 7;
  localparam int CTRL_IRQ_EN = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RESET = 9'h0c4;
  // status fields
  localparam int ST_DISC = 0;
  localparam int ST_ERR = 1;
  localparam int ST_ACK_REQ = 2;
  localparam int ST_FRESH = 3;
  localparam int ST_PV_LO = 16;
  // tolerance fields, tenths of a percent
  localparam int TOL_ABS_LO = 0;
  localparam int TOL_REL_LO = 8;
  localparam logic [7:0] TOL_MIN = 8'h02;
  localparam logic [7:0] TOL_MAX = 8'hc8;
  localparam logic [7:0] TOL_RESET = 8'h19;
  localparam logic [31:0] TOL_DIV = 32'h0000_03e8;
  // currents in microamps
  localparam logic [15:0] RANGE_END = 16'h4e20;
  localparam logic [15:0] START_4MA = 16'h0fa0;
  localparam logic [15:0] START_0MA = 16'h0000;
  localparam logic [15:0] ERR_CODE = 16'h7fff;
  // discrepancy time, ms written, held in 10 ms units
  localparam logic [15:0] DISC_MAX_MS = 16'h7530;
  localparam logic [15:0] DISC_STEP_MS = 16'h000a;
  localparam logic [15:0] DISC_MIN_UNITS = 16'h0002;
  localparam logic [15:0] DISC_RESET_UNITS = 16'h000f;
  // timebase
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_TIME_NS = 10_000_000;
  localparam int CONV_TIME_NS = 125_000_000;
  localparam int STEP_CYC = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
endpackage : dcc_pkg

//--- hdl/dcc_smoother.sv
// block-average smoothing filter for one channel
`timescale 1ns/1ps
`default_nettype none
module dcc_smoother (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // control
  input wire logic sample_en,
  input wire logic restart,
  input wire logic [1:0] depth_code,
  // data
  input wire logic [15:0] sample,
  output logic [15:0] avg_ff,
  output logic valid_ff
);
  logic [21:0] acc_ff;
  logic [6:0] cnt_ff;
  logic [21:0] sum;
  logic [6:0] last_idx;
  logic [4:0] shift;

  // depth is 4^code samples; code 0 passes samples straight through
  assign shift = {2'h0, depth_code, 1'b0};
  assign last_idx = 7'((7'h01 << shift) - 7'h01);
  assign sum = acc_ff + {6'h00, sample};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 22'h000000;
      cnt_ff <= 7'h00;
      avg_ff <= 16'h0000;
      valid_ff <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        acc_ff <= 22'h000000;
        cnt_ff <= 7'h00;
        valid_ff <= 1'b0;
      end else if (sample_en) begin
        if (cnt_ff >= last_idx) begin
          avg_ff <= 16'(sum >> shift);
          acc_ff <= 22'h000000;
          cnt_ff <= 7'h00;
          valid_ff <= 1'b1;
        end else begin
          acc_ff <= sum;
          cnt_ff <= cnt_ff + 7'h01;
        end
      end
    end
  end
endmodule : dcc_smoother
`default_nettype wire

//--- tb/dcc_ctrl_model.sv
// fail-safe controller model watching the process side of the checker
`timescale 1ns/1ps
`default_nettype none
module dcc_ctrl_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // process side
  input wire logic [15:0] process_value,
  input wire logic disc_error,
  input wire logic diag_irq,
  // observations
  output int irq_count,
  output logic [15:0] last_good_pv
);
  // ==========================================================
  // interrupt count; the pulse lasts one cycle, so every edge counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_count <= 0;
    end else if (diag_irq) begin
      irq_count <= irq_count + 1;
    end
  end
  // ==========================================================
  // the controller substitutes its own safe value, so it keeps the last usable one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_good_pv <= 16'h0000;
    end else if (!disc_error && process_value !== dcc_pkg::ERR_CODE) begin
      last_good_pv <= process_value;
    end
  end
endmodule : dcc_ctrl_model
`default_nettype wire

//--- tb/dual_channel_discrepancy_checker_bench.sv
// self-checking bench of the dual channel discrepancy checker
`timescale 1ns/1ps
`default_nettype none
module dual_channel_discrepancy_checker_bench;
  // ==========================================================
  // clock, reset and stimulus
  localparam int STEP = 10;
  localparam int CONV = 40;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [15:0] ch_a = 16'h2710;
  logic [15:0] ch_b = 16'h2710;
  logic flt_a = 1'b0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [15:0] pv;
  wire logic disc;
  wire logic err;
  wire logic ackr;
  wire logic irq;
  int irq_cnt;
  logic [15:0] good_pv;
  logic [31:0] rd;
  int errors = 0;
  int checks = 0;
  always #10 hclk = ~hclk;
  dcc_checker #(.STEP_CYC(STEP), .CONV_CYC(CONV)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ch_a_in(ch_a), .ch_b_in(ch_b), .ch_a_fault(flt_a),
    .ch_b_fault(1'b0), .process_value(pv), .disc_active(disc), .disc_error(err),
    .ack_required(ackr), .diag_irq(irq));
  dcc_ctrl_model u_ctrl (
    .hclk(hclk), .hresetn(hresetn), .process_value(pv), .disc_error(err), .diag_irq(irq),
    .irq_count(irq_cnt), .last_good_pv(good_pv));
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // single word transfer; read data is taken at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic tk(input int n);
    repeat (n * CONV) @(posedge hclk);
  endtask : tk
  task automatic setb(input logic [15:0] v);
    @(posedge hclk);
    ch_b <= v;
  endtask : setb
  task automatic look(input logic [15:0] exp_pv, input logic exp_disc);
    chk("process_value", 32'(pv), 32'(exp_pv));
    chk("disc_active", 32'(disc), 32'(exp_disc));
  endtask : look
  // ==========================================================
  // scenarios
  task automatic t_regs;
    bus(1'b0, dcc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0000_00c4);
    chk("hresp", 32'(hresp), 32'h0);
    bus(1'b0, dcc_pkg::ADDR_DISC_TIME, 32'h0);
    chk("disc reset", rd, 32'h0000_000f);
    bus(1'b0, dcc_pkg::ADDR_STATUS, 32'h0);
    chk("status pv", {16'h0000, rd[31:16]}, 32'h0000_7fff);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1'b1, dcc_pkg::ADDR_DISC_TIME, 32'h0000_0000);
    bus(1'b0, dcc_pkg::ADDR_DISC_TIME, 32'h0);
    chk("disc zero", rd, 32'h0000_0000);
    bus(1'b1, dcc_pkg::ADDR_DISC_TIME, 32'h0000_0003);
    bus(1'b0, dcc_pkg::ADDR_DISC_TIME, 32'h0);
    chk("disc minimum", rd, 32'h0000_0002);
    bus(1'b1, dcc_pkg::ADDR_DISC_TIME, 32'h0000_001a);
    bus(1'b0, dcc_pkg::ADDR_DISC_TIME, 32'h0);
    chk("disc rounding", rd, 32'h0000_0003);
    bus(1'b1, dcc_pkg::ADDR_TOL, 32'h0000_c801);
    bus(1'b0, dcc_pkg::ADDR_TOL, 32'h0);
    chk("tolerance range", rd, 32'h0000_c819);
    $display("test regs done");
  endtask : t_regs
  task automatic t_window;
    bus(1'b1, dcc_pkg::ADDR_DISC_TIME, 32'h0000_03e8);
    setb(16'h3a98);
    tk(3);
    look(16'h2710, 1'b0);
    setb(16'h283c);
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_0045);
    tk(3);
    look(16'h2710, 1'b0);
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_0047);
    tk(3);
    look(16'h283c, 1'b0);
    setb(16'h28d2);
    tk(3);
    look(16'h283c, 1'b1);
    chk("smoothing kept", 32'(u_dut.valid_b), 32'h1);
    setb(16'h283c);
    tk(3);
    look(16'h283c, 1'b0);
    setb(16'h28d2);
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_0043);
    tk(3);
    look(16'h28d2, 1'b0);
    setb(16'h2b5c);
    bus(1'b1, dcc_pkg::ADDR_TOL, 32'h0000_c802);
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_0085);
    tk(3);
    look(16'h2710, 1'b0);
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_0045);
    tk(3);
    chk("disc abs only", 32'(disc), 32'h1);
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_00c5);
    tk(3);
    look(16'h2710, 1'b0);
    $display("test window done");
  endtask : t_window
  task automatic t_expiry;
    int n;
    int irq0;
    bus(1'b1, dcc_pkg::ADDR_DISC_TIME, 32'h0000_0014);
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_01c5);
    setb(16'h2710);
    tk(3);
    irq0 = irq_cnt;
    setb(16'h3a98);
    n = 0;
    while (err !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk("error latency", 32'(n <= 2 * CONV + 2 * STEP + 2 * CONV), 32'h1);
    @(posedge hclk);
    chk("pv on error", 32'(pv), 32'h7fff);
    chk("irq count", 32'(irq_cnt - irq0), 32'h1);
    chk("good pv", 32'(good_pv), 32'h2710);
    setb(16'h2710);
    tk(3);
    chk("error sticky", 32'(err), 32'h1);
    bus(1'b1, dcc_pkg::ADDR_ACK, 32'h0000_0001);
    tk(3);
    chk("error cleared", 32'(err), 32'h0);
    chk("pv after ack", 32'(pv), 32'h2710);
    $display("test expiry done");
  endtask : t_expiry
  task automatic t_heal;
    int irq0;
    irq0 = irq_cnt;
    // a pulse one conversion cycle long is sampled once, so it heals before the expiry check
    setb(16'h3a98);
    repeat (CONV - 1) @(posedge hclk);
    setb(16'h2710);
    tk(3);
    chk("ack required", 32'(ackr), 32'h1);
    chk("no error", 32'(err), 32'h0);
    chk("no irq", 32'(irq_cnt - irq0), 32'h0);
    chk("pv healed", 32'(pv), 32'h2710);
    bus(1'b1, dcc_pkg::ADDR_ACK, 32'h0000_0001);
    @(posedge hclk);
    chk("ack cleared", 32'(ackr), 32'h0);
    $display("test heal done");
  endtask : t_heal
  // depth four after a fault restart: no value before the fourth sample
  task automatic t_smooth;
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_0014);
    tk(2);
    @(posedge hclk);
    flt_a <= 1'b1;
    ch_a <= 16'h2ee0;
    repeat (5) @(posedge hclk);
    flt_a <= 1'b0;
    tk(3);
    chk("pv before average", 32'(pv), 32'h2710);
    tk(3);
    chk("pv averaged", 32'(pv), 32'h2ee0);
    @(posedge hclk);
    ch_a <= 16'h2710;
    bus(1'b1, dcc_pkg::ADDR_CTRL, 32'h0000_01c5);
    $display("test smooth done");
  endtask : t_smooth
  task automatic t_fault;
    int n;
    @(posedge hclk);
    flt_a <= 1'b1;
    ch_b <= 16'h3a98;
    repeat (5) @(posedge hclk);
    flt_a <= 1'b0;
    n = 0;
    while (disc !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    look(16'h7fff, 1'b1);
    $display("test fault done");
  endtask : t_fault
  // ==========================================================
  // run control
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_window();
    t_expiry();
    t_heal();
    t_smooth();
    t_fault();
    wrap_up();
  end
  // the whole sequence needs some 2200 cycles; nearly fourteen times that means a hang
  initial begin
    repeat (30000) @(posedge hclk);
    errors++;
    $display("unexpected run length: expected finish seen hang");
    wrap_up();
  end
endmodule : dual_channel_discrepancy_checker_bench
`default_nettype wire
